// ===== rtl/flc_host.sv
/*
  flc_host: host-side sequencer for a command-register flash. Runs array
  read, identifier read, pulsed byte program and full chip erase.
  assumes o_program_supply_high switches the flash programming supply and
  that the flash data pins are resolved outside from o_fl_dq_oe.
*/
`timescale 1ns/1ps
`default_nettype none

module flc_host
  import flc_pkg::*;
#(
  parameter int VPP_CYC = VPP_CYC_DEF,
  parameter int ERASE_CYC = ERASE_CYC_DEF,
  parameter int MAX_PULSES = MAX_PULSES_DEF,
  parameter int MAX_ERASES = MAX_ERASES_DEF,
  parameter int LAST_ADDR = (1 << ADDR_W) - 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // request port
  input wire logic i_start,
  input wire flc_req_t i_req,
  output logic o_busy,
  output logic o_done,
  output logic o_fail,
  output logic [DATA_W-1:0] o_rdata,
  // flash pins
  output logic [ADDR_W-1:0] o_fl_addr,
  output logic [DATA_W-1:0] o_fl_dq_out,
  output logic o_fl_dq_oe,
  input wire logic [DATA_W-1:0] i_fl_dq_in,
  output logic o_fl_ce_n,
  output logic o_fl_oe_n,
  output logic o_fl_we_n,
  output logic o_program_supply_high
);

  typedef enum logic [4:0] {
    S_IDLE, S_VPP_UP, S_CMD_RD, S_READ,
    S_PP_SETUP, S_PP_DATA, S_PP_WAIT, S_PP_VCMD, S_PP_REC, S_PP_READ,
    S_ER_SETUP, S_ER_GO, S_ER_WAIT, S_ER_VCMD, S_ER_REC, S_ER_READ,
    S_RST1, S_RST2, S_EXIT, S_VPP_DN, S_FIN
  } flc_st_t;

  flc_st_t st_q;
  flc_req_t req_q;
  logic [31:0] cnt_q;
  logic sent_q;
  logic preprog_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] pulses_q;
  logic [15:0] erases_q;
  logic [31:0] pw_q;
  flc_cyc_t cyc;
  logic cyc_start;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic [DATA_W-1:0] pdata;
  logic is_id;
  logic pp_match;
  logic er_match;

  function automatic logic is_last(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(LAST_ADDR);
  endfunction

  function automatic logic is_bus(input flc_st_t s);
    return !(s inside {S_IDLE, S_VPP_UP, S_PP_WAIT, S_PP_REC,
                       S_ER_WAIT, S_ER_REC, S_VPP_DN, S_FIN});
  endfunction

  assign is_id = (req_q.op == FLC_OP_ID);
  assign pdata = preprog_q ? PREPROG_BYTE : req_q.data;
  assign cyc_start = is_bus(st_q) && !sent_q;
  assign pp_match = (cyc_rdata == pdata);
  assign er_match = (cyc_rdata == ERASED_BYTE);

  // cycle to place on the pins for each bus state
  always_comb begin
    cyc = '{wr: 1'b1, addr: addr_q, data: CMD_READ};
    unique case (st_q)
      S_CMD_RD: cyc.data = is_id ? CMD_ID : CMD_READ;
      S_READ: begin
        cyc.wr = 1'b0;
        // identifier bytes sit at addresses 0 and 1
        cyc.addr = is_id ? {{(ADDR_W-1){1'b0}}, addr_q[0]} : addr_q;
      end
      S_PP_SETUP: cyc.data = CMD_PROG;
      S_PP_DATA: cyc.data = pdata;
      S_PP_VCMD: cyc.data = CMD_PVFY;
      S_PP_READ: cyc.wr = 1'b0;
      S_ER_SETUP, S_ER_GO: cyc.data = CMD_ERASE;
      S_ER_VCMD: cyc.data = CMD_EVFY;
      S_ER_READ: cyc.wr = 1'b0;
      S_RST1, S_RST2: cyc.data = CMD_RESET;
      default: cyc.data = CMD_READ;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sent_q <= 1'b0;
    end else if (cyc_done) begin
      sent_q <= 1'b0;
    end else if (cyc_start) begin
      sent_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      req_q <= '0;
    end else if (st_q == S_IDLE && i_start) begin
      req_q <= i_req;
    end
  end

  // main sequencer with its wait counter
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
    end else begin
      if (cnt_q != 32'h0) begin
        cnt_q <= cnt_q - 32'h1;
      end
      unique case (st_q)
        S_IDLE: if (i_start) begin
          if (i_req.op == FLC_OP_READ) begin
            st_q <= S_CMD_RD;
          end else begin
            st_q <= S_VPP_UP;
            cnt_q <= 32'(VPP_CYC - 1);
          end
        end
        S_VPP_UP: if (cnt_q == 32'h0) begin
          st_q <= is_id ? S_CMD_RD : S_PP_SETUP;
        end
        S_CMD_RD: if (cyc_done) st_q <= S_READ;
        S_READ: if (cyc_done) st_q <= is_id ? S_EXIT : S_FIN;
        S_PP_SETUP: if (cyc_done) st_q <= S_PP_DATA;
        S_PP_DATA: if (cyc_done) begin
          st_q <= S_PP_WAIT;
          cnt_q <= 32'(PROG_CYC - 1);
        end
        S_PP_WAIT: if (cnt_q == 32'h0) st_q <= S_PP_VCMD;
        S_PP_VCMD: if (cyc_done) begin
          st_q <= S_PP_REC;
          cnt_q <= 32'(REC_CYC - 1);
        end
        S_PP_REC: if (cnt_q == 32'h0) st_q <= S_PP_READ;
        S_PP_READ: if (cyc_done) begin
          if (pp_match) begin
            if (!preprog_q) st_q <= S_EXIT;
            else if (is_last(addr_q)) st_q <= S_ER_SETUP;
            else st_q <= S_PP_SETUP;
          end else if (32'(pulses_q) >= 32'(MAX_PULSES)) begin
            st_q <= S_RST1;
          end else begin
            st_q <= S_PP_SETUP;
          end
        end
        S_ER_SETUP: if (cyc_done) st_q <= S_ER_GO;
        S_ER_GO: if (cyc_done) begin
          st_q <= S_ER_WAIT;
          cnt_q <= 32'(ERASE_CYC - 1);
        end
        S_ER_WAIT: if (cnt_q == 32'h0) st_q <= S_ER_VCMD;
        S_ER_VCMD: if (cyc_done) begin
          st_q <= S_ER_REC;
          cnt_q <= 32'(REC_CYC - 1);
        end
        S_ER_REC: if (cnt_q == 32'h0) st_q <= S_ER_READ;
        S_ER_READ: if (cyc_done) begin
          if (er_match) begin
            st_q <= is_last(addr_q) ? S_EXIT : S_ER_VCMD;
          end else if (32'(erases_q) >= 32'(MAX_ERASES)) begin
            st_q <= S_RST1;
          end else begin
            st_q <= S_ER_SETUP;
          end
        end
        S_RST1: if (cyc_done) st_q <= S_RST2;
        S_RST2: if (cyc_done) st_q <= S_EXIT;
        S_EXIT: if (cyc_done) begin
          st_q <= S_VPP_DN;
          cnt_q <= 32'(VPP_CYC - 1);
        end
        S_VPP_DN: if (cnt_q == 32'h0) st_q <= S_FIN;
        S_FIN: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // byte address walk and preprogram flag
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_q <= '0;
      preprog_q <= 1'b0;
    end else if (st_q == S_IDLE && i_start) begin
      addr_q <= (i_req.op == FLC_OP_ERASE) ? '0 : i_req.addr;
      preprog_q <= (i_req.op == FLC_OP_ERASE);
    end else if (st_q == S_PP_READ && cyc_done && pp_match && preprog_q) begin
      addr_q <= is_last(addr_q) ? '0 : addr_q + ADDR_W'(1);
      preprog_q <= !is_last(addr_q);
    end else if (st_q == S_ER_READ && cyc_done && er_match) begin
      addr_q <= addr_q + ADDR_W'(1);
    end
  end

  // pulse and erase counts
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pulses_q <= '0;
      erases_q <= '0;
    end else begin
      if (st_q == S_IDLE || (st_q == S_PP_READ && cyc_done && pp_match)) begin
        pulses_q <= '0;
      end else if (st_q == S_PP_DATA && cyc_done) begin
        pulses_q <= pulses_q + 8'h01;
      end
      if (st_q == S_IDLE) begin
        erases_q <= '0;
      end else if (st_q == S_ER_GO && cyc_done) begin
        erases_q <= erases_q + 16'h0001;
      end
    end
  end

  // programming supply: raised before any command write of an identifier read, program or erase; array read writes without it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_program_supply_high <= 1'b0;
    end else if (st_q == S_IDLE && i_start && i_req.op != FLC_OP_READ) begin
      o_program_supply_high <= 1'b1;
    end else if (st_q == S_EXIT && cyc_done) begin
      o_program_supply_high <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
      o_rdata <= '0;
    end else begin
      o_done <= (st_q == S_FIN);
      if (st_q == S_IDLE && i_start) begin
        o_busy <= 1'b1;
        o_fail <= 1'b0;
      end else if (st_q == S_FIN) begin
        o_busy <= 1'b0;
      end
      if (st_q == S_RST1 && cyc_start) begin
        o_fail <= 1'b1;
      end
      if (st_q == S_READ && cyc_done) begin
        o_rdata <= cyc_rdata;
      end
    end
  end

  flc_bus_cycle u_cycle (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(cyc_start),
    .i_cyc(cyc),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_addr(o_fl_addr),
    .o_dq_out(o_fl_dq_out),
    .o_dq_oe(o_fl_dq_oe),
    .i_dq_in(i_fl_dq_in),
    .o_ce_n(o_fl_ce_n),
    .o_oe_n(o_fl_oe_n),
    .o_we_n(o_fl_we_n)
  );

  // cycles spent in the current program pulse
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pw_q <= '0;
    end else if (st_q == S_PP_WAIT) begin
      pw_q <= pw_q + 32'h1;
    end else begin
      pw_q <= '0;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  chk_pulse_width: assert property (
    $fell(st_q == S_PP_WAIT) |-> $past(pw_q) == 32'(PROG_CYC - 1))
    else $error("program pulse length wrong");
  chk_verify_follows: assert property (
    $fell(st_q == S_PP_WAIT) |-> st_q == S_PP_VCMD)
    else $error("program pulse not followed by verify command");
  chk_pulse_cap: assert property (
    32'(pulses_q) <= 32'(MAX_PULSES))
    else $error("more program pulses than allowed");
  chk_erase_supply: assert property (
    st_q inside {S_ER_SETUP, S_ER_GO, S_ER_WAIT} |-> o_program_supply_high)
    else $error("erase sequence without programming supply");
  chk_two_step_erase: assert property (
    $rose(st_q == S_ER_WAIT) |-> $past(st_q) == S_ER_GO
    && $past(cyc.data) == CMD_ERASE)
    else $error("erase started without second erase write");
  chk_preprog_first: assert property (
    $rose(st_q == S_ER_SETUP) |-> !preprog_q)
    else $error("erase before preprogram finished");
  chk_verify_addr: assert property (
    cyc_start && st_q == S_ER_VCMD |-> ##1 o_fl_addr == addr_q
    && o_fl_dq_out == CMD_EVFY)
    else $error("erase verify write without byte address");
  chk_leave_read: assert property (
    $rose(st_q == S_VPP_DN) |-> $past(st_q) == S_EXIT
    && $past(cyc.data) == CMD_READ)
    else $error("supply dropped before read command");
  chk_done_pulse: assert property (
    o_done |=> !o_done && !o_busy)
    else $error("done not a single pulse");

  cov_prog_ok: cover property (
    $rose(st_q == S_EXIT) && req_q.op == FLC_OP_PROG && !o_fail);
  cov_reerase: cover property (
    st_q == S_ER_READ && cyc_done && !er_match);
  cov_fail: cover property ($rose(o_fail));
  cov_id_read: cover property (
    st_q == S_READ && cyc_done && is_id);

endmodule // flc_host

`default_nettype wire

// ===== shared/flc_pkg.sv
/*
  flc_pkg: constants, command codes, timing counts and carriers for the
  flash command host.
  assumes a byte-wide flash whose command register is reached through its
  strobe pins, and a 100 MHz host clock.
*/
// Operation
// - 00H write selects array read
// - after 90H, addresses 0/1 give ids
// - id mode stays until another command
// - A0H latches address, ends erase
// - host verifies each byte with A0H
// - on mismatch re-erase, resume at address
// - host leaves verify with valid command
// - host compares verify byte, advances on match
// - 10 us pulses, verify each, max 25
// - preprogram whole array to 00H before erase
// - write needs strobe and select both low

package flc_pkg;

  localparam int CLK_MHZ = 100;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_EVFY = 8'hA0;
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PVFY = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] PREPROG_BYTE = 8'h00;

  // program pulse, write strobe, access and verify recovery times
  localparam int T_PROG_NS = 10000;
  localparam int T_WE_NS = 100;
  localparam int T_ACC_NS = 150;
  localparam int T_WHGL_NS = 6000;
  localparam int T_ERASE_MS = 10;
  localparam int T_VPP_US = 100;
  localparam int PROG_CYC = (T_PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_CYC = (T_WE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int REC_CYC = (T_WHGL_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYC_DEF = T_ERASE_MS * 1000 * CLK_MHZ;
  localparam int VPP_CYC_DEF = T_VPP_US * CLK_MHZ;
  localparam int MAX_PULSES_DEF = 25;
  localparam int MAX_ERASES_DEF = 1000;

  typedef enum logic [1:0] {
    FLC_OP_READ,
    FLC_OP_ID,
    FLC_OP_PROG,
    FLC_OP_ERASE
  } flc_op_t;

  typedef struct packed {
    flc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } flc_req_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } flc_cyc_t;

endpackage

// ===== rtl/flc_bus_cycle.sv
/*
  flc_bus_cycle: runs one write or one read cycle on the flash pins.
  assumes the caller starts a cycle only after the previous o_done.
*/
`timescale 1ns/1ps
`default_nettype none

module flc_bus_cycle
  import flc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // cycle request and answer
  input wire logic i_start,
  input wire flc_cyc_t i_cyc,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  // flash pins
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [DATA_W-1:0] i_dq_in,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n
);

  localparam int RD_CYC = ACC_CYC + 2;

  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_WE, C_HOLD, C_RD} flc_cst_t;

  flc_cst_t st_q;
  logic [7:0] cnt_q;
  logic wr_q;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= i_dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= C_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= '0;
      o_addr <= '0;
      o_dq_out <= '0;
      o_dq_oe <= 1'b0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
    end else begin
      o_done <= 1'b0;
      unique case (st_q)
        C_IDLE: if (i_start) begin
          // address settles before the falling strobe
          o_addr <= i_cyc.addr;
          o_dq_out <= i_cyc.data;
          wr_q <= i_cyc.wr;
          o_ce_n <= 1'b0;
          st_q <= C_SETUP;
        end
        C_SETUP: begin
          if (wr_q) begin
            o_we_n <= 1'b0;
            o_dq_oe <= 1'b1;
            cnt_q <= 8'(WE_CYC - 1);
            st_q <= C_WE;
          end else begin
            o_oe_n <= 1'b0;
            cnt_q <= 8'(RD_CYC - 1);
            st_q <= C_RD;
          end
        end
        C_WE: begin
          if (cnt_q == 8'h00) begin
            o_we_n <= 1'b1;
            st_q <= C_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        C_HOLD: begin
          // data held one cycle past the rising strobe
          o_ce_n <= 1'b1;
          o_dq_oe <= 1'b0;
          o_done <= 1'b1;
          st_q <= C_IDLE;
        end
        C_RD: begin
          if (cnt_q == 8'h00) begin
            o_rdata <= dq_s2_q;
            o_oe_n <= 1'b1;
            o_ce_n <= 1'b1;
            o_done <= 1'b1;
            st_q <= C_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
      endcase
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  chk_we_with_ce: assert property (!o_we_n |-> !o_ce_n && o_oe_n)
    else $error("write strobe low without select or with output on");
  chk_data_at_rise: assert property ($rose(o_we_n) |-> o_dq_oe && !o_ce_n)
    else $error("data not held at rising write strobe");
  chk_we_width: assert property ($fell(o_we_n) |-> (!o_we_n)[*8])
    else $error("write strobe pulse too short");

endmodule // flc_bus_cycle

`default_nettype wire

// ===== bench/flc_flash_model.sv
/*
  flc_flash_model: behavioural byte-wide command-register flash.
  assumes the bench resolves the data pins and sets pulses a byte needs.
*/
`timescale 1ns/1ps
`default_nettype none

module flc_flash_model
  import flc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5C, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3E, // arbitrary value
  // bytes that must hold 00H before an erase may start
  parameter int ARRAY_BYTES = 1 << ADDR_W,
  // stop-timer limits, no shorter than the host's pulses
  parameter int STOP_PROG_NS = 100000,
  parameter int STOP_ERASE_NS = 20000000
) (
  // pins from the host
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_program_supply_high,
  // pulses a byte needs before it holds
  input wire logic [7:0] i_need_pulses,
  // read drive and observations
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic [7:0] o_pulses,
  output logic [7:0] o_faults
);
  typedef enum logic [3:0] {
    M_READ, M_ID, M_ESET, M_ERASE, M_EVFY, M_PSET, M_PROG, M_PVFY, M_ABORT
  } flc_mstate_t;
  flc_mstate_t st;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] wa, ea, pa;
  logic [DATA_W-1:0] pd;
  realtime t0;

  initial begin
    st = M_READ;
    o_pulses = 8'h00;
    o_faults = 8'h00;
    pa = '1;
    for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = ERASED_BYTE;
  end

  // any supply edge drops back to array read
  always @(i_program_supply_high) st = M_READ;

  always @(negedge i_we_n) begin
    if (i_ce_n === 1'b0) wa = i_addr;
  end

  always @(posedge i_we_n) begin
    if (i_ce_n === 1'b0 && i_program_supply_high === 1'b1) begin
      take(i_dq);
    end
  end

  task automatic take(input logic [DATA_W-1:0] d);
    logic bad;
    logic stop;
    bad = 1'b0;
    // an overlong pulse was already ended by the stop timer
    stop = (st == M_PROG && $realtime - t0 > STOP_PROG_NS) ||
           (st == M_ERASE && $realtime - t0 > STOP_ERASE_NS);
    if (st == M_PROG) begin
      if ($realtime - t0 < T_PROG_NS) o_faults++;
      if (o_pulses >= i_need_pulses) mem[pa] = mem[pa] & pd;
    end
    if (st == M_ERASE) begin
      for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = ERASED_BYTE;
    end
    // inactive after a timer stop until verify or reset
    if (stop && !(d inside {CMD_PVFY, CMD_EVFY, CMD_RESET})) return;
    if ((st == M_ESET || st == M_PSET) && d == CMD_RESET) begin
      st = M_ABORT;
    end else if (st == M_ABORT && d == CMD_RESET) begin
      st = M_READ;
    end else if (st == M_PSET) begin
      if (wa != pa) o_pulses = 8'h00;
      pa = wa;
      pd = d;
      o_pulses++;
      if (o_pulses > 8'd25) o_faults++;
      t0 = $realtime;
      st = M_PROG;
    end else if (st == M_ESET && d == CMD_ERASE) begin
      for (int i = 0; i < ARRAY_BYTES; i++) begin
        if (mem[i] !== PREPROG_BYTE) bad = 1'b1;
      end
      if (bad) o_faults++;
      t0 = $realtime;
      st = M_ERASE;
    end else begin
      case (d)
        CMD_READ: st = M_READ;
        CMD_ID: st = M_ID;
        CMD_ERASE: st = M_ESET;
        CMD_EVFY: begin
          ea = wa;
          st = M_EVFY;
        end
        CMD_PROG: st = M_PSET;
        CMD_PVFY: st = M_PVFY;
        default: ;
      endcase
    end
  endtask

  always_comb begin
    o_dq_oe = !i_ce_n && !i_oe_n && i_we_n;
    case (st)
      M_ID: o_dq = i_addr[0] ? PART_CODE : MAKER_CODE;
      M_EVFY: o_dq = mem[ea];
      M_PVFY: o_dq = mem[pa];
      default: o_dq = mem[i_addr];
    endcase
  end
endmodule // flc_flash_model

`default_nettype wire

// ===== bench/flc_host_test.sv
/*
  flc_host_test: self-checking bench for the flash command host.
  assumes shortened supply and erase counts; the flash is a model.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      n_mismatch++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

module flc_host_test;
  import flc_pkg::*;
  localparam logic [7:0] MAKER = 8'h5C; // arbitrary value
  localparam logic [7:0] PART = 8'h3E; // arbitrary value
  localparam int LIMIT = 95000;
  typedef struct {
    flc_op_t op;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [7:0] np;
    logic [DATA_W-1:0] exp;
  } flc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  flc_req_t req = '0;
  logic [7:0] need = 8'h01;
  logic [DATA_W-1:0] idle_pat = 8'hA5;
  logic busy, done, fail, dq_oe, ce_n, oe_n, we_n, supply, dev_oe;
  logic [DATA_W-1:0] rdata, dq_out, dq_in, dev_dq;
  logic [ADDR_W-1:0] addr;
  logic [7:0] pulses, faults;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  flc_row_t rows [10] = '{
    '{FLC_OP_PROG, 15'h0005, 8'h5A, 8'h01, 8'h00},
    '{FLC_OP_READ, 15'h0005, 8'h00, 8'h01, 8'h5A},
    '{FLC_OP_PROG, 15'h7FFF, 8'hC3, 8'h03, 8'h00},
    '{FLC_OP_READ, 15'h7FFF, 8'h00, 8'h01, 8'hC3},
    '{FLC_OP_ID, 15'h0000, 8'h00, 8'h01, MAKER},
    '{FLC_OP_ID, 15'h0001, 8'h00, 8'h01, PART},
    '{FLC_OP_ID, 15'h7FFF, 8'h00, 8'h01, PART},
    '{FLC_OP_READ, 15'h0004, 8'h00, 8'h01, 8'hFF},
    '{FLC_OP_PROG, 15'h0005, 8'h00, 8'h01, 8'h00},
    '{FLC_OP_READ, 15'h0005, 8'h00, 8'h01, 8'h00}
  };

  flc_host #(.VPP_CYC(4), .ERASE_CYC(20), .MAX_ERASES(3), .LAST_ADDR(3))
    u_flc_host (
    .i_clk(clk), .i_sys_rst(rst), .i_start(start), .i_req(req),
    .o_busy(busy), .o_done(done), .o_fail(fail), .o_rdata(rdata),
    .o_fl_addr(addr), .o_fl_dq_out(dq_out), .o_fl_dq_oe(dq_oe),
    .i_fl_dq_in(dq_in), .o_fl_ce_n(ce_n), .o_fl_oe_n(oe_n),
    .o_fl_we_n(we_n), .o_program_supply_high(supply)
  );

  flc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .ARRAY_BYTES(4))
    u_flc_flash_model (
    .i_addr(addr), .i_dq(dq_out), .i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_program_supply_high(supply), .i_need_pulses(need),
    .o_dq(dev_dq), .o_dq_oe(dev_oe), .o_pulses(pulses), .o_faults(faults)
  );

  always #5 clk = ~clk;
  // undriven pins show a changing pattern, not the last value
  always @(posedge clk) idle_pat <= ~idle_pat;
  assign dq_in = dev_oe ? dev_dq : (dq_oe ? dq_out : idle_pat);

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      $display("[FAIL] cycles expected %0d seen %0d", LIMIT - 1, cyc);
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic go(input flc_op_t op, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    @(negedge clk);
    start = 1'b1;
    req = '{op, a, d};
    @(negedge clk);
    start = 1'b0;
  endtask

  task automatic wait_done();
    for (int n = 0; n < 50000; n++) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    `CHK("done", 1'b1, done);
  endtask

  task automatic run(input flc_op_t op, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    go(op, a, d);
    wait_done();
  endtask

  task automatic chk_idle();
    `CHK("we_n", 1'b1, we_n);
    `CHK("ce_n", 1'b1, ce_n);
    `CHK("oe_n", 1'b1, oe_n);
    `CHK("dq_oe", 1'b0, dq_oe);
    `CHK("supply", 1'b0, supply);
    `CHK("busy", 1'b0, busy);
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk_idle();
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      need = rows[i].np;
      run(rows[i].op, rows[i].a, rows[i].d);
      `CHK("fail", 1'b0, fail);
      if (rows[i].op == FLC_OP_PROG) begin
        `CHK("pulses", rows[i].np, pulses);
      end else begin
        `CHK("rdata", rows[i].exp, rdata);
      end
      $display("test row %0d done", i);
    end
    // byte that never takes: host must give up at the pulse limit
    need = 8'd26;
    run(FLC_OP_PROG, 15'h0100, 8'h00);
    `CHK("fail", 1'b1, fail);
    `CHK("pulses", 8'd25, pulses);
    need = 8'h01;
    run(FLC_OP_READ, 15'h0100, 8'h00);
    `CHK("rdata", 8'hFF, rdata);
    `CHK("fail", 1'b0, fail);
    $display("test pulse limit done");
    // start while busy is dropped
    go(FLC_OP_READ, 15'h7FFF, 8'h00);
    repeat (3) @(negedge clk);
    `CHK("busy", 1'b1, busy);
    go(FLC_OP_PROG, 15'h0200, 8'h00);
    wait_done();
    `CHK("rdata", 8'hC3, rdata);
    run(FLC_OP_READ, 15'h0200, 8'h00);
    `CHK("rdata", 8'hFF, rdata);
    $display("test busy refusal done");
    // full erase of the shortened array, then a far byte reads erased
    run(FLC_OP_ERASE, 15'h0000, 8'h00);
    `CHK("fail", 1'b0, fail);
    `CHK("faults", 8'h00, faults);
    run(FLC_OP_READ, 15'h7FFF, 8'h00);
    `CHK("rdata", ERASED_BYTE, rdata);
    $display("test erase done");
    // reset in mid-erase, once preprogramming has reached byte 1
    go(FLC_OP_ERASE, 15'h0000, 8'h00);
    for (int n = 0; n < 20000; n++) begin
      if (addr === 15'h0001 && we_n === 1'b0) break;
      @(negedge clk);
    end
    `CHK("supply", 1'b1, supply);
    rst = 1'b1;
    @(negedge clk);
    chk_idle();
    rst = 1'b0;
    @(negedge clk);
    chk_idle();
    run(FLC_OP_READ, 15'h0000, 8'h00);
    `CHK("rdata", PREPROG_BYTE, rdata);
    `CHK("faults", 8'h00, faults);
    $display("test erase reset done");
    close_out();
  end
endmodule // flc_host_test

`default_nettype wire
